// ---- logic/rtg_defines.svh ----
/*
 * Offsets, field positions, reset values and divider counts of the trim,
 * guard and alert logic. Assumes a 4-bit register address from the serial
 * engine and a 32.768 kHz oscillator counted in oscillator cycles.
 */
`ifndef RTG_DEFINES_SVH
`define RTG_DEFINES_SVH

// Register offsets.
`define RTG_ADDR_CLOCK_LAST 4'h7
`define RTG_ADDR_TRIM       4'h8
`define RTG_ADDR_GUARD      4'h9
`define RTG_ADDR_MONTH      4'hA
`define RTG_ADDR_DATE       4'hB
`define RTG_ADDR_HOUR       4'hC
`define RTG_ADDR_MINUTE     4'hD
`define RTG_ADDR_SECOND     4'hE
`define RTG_ADDR_FLAGS      4'hF

// Field positions.
`define RTG_TRIM_OUT_BIT    7
`define RTG_TRIM_SIGN_BIT   5
`define RTG_AFE_BIT         7
`define RTG_WDF_BIT         7
`define RTG_AF_BIT          6
`define RTG_OF_BIT          2

// Reset values.
`define RTG_TRIM_RST        8'h80
`define RTG_GUARD_RST       8'h00
`define RTG_MONTH_RST       8'h40
`define RTG_ALERT_RST       8'h00

// Second length in oscillator cycles and trim corrections.
`define RTG_SEC_OSC         16'h8000
`define RTG_TRIM_CUT        16'h0100
`define RTG_TRIM_ADD        16'h0080
`define RTG_SEC_PER_MIN_M1  6'h3B

// Guard tick periods in oscillator cycles, minus one.
`define RTG_WD_16HZ_M1      21'h0007FF
`define RTG_WD_4HZ_M1       21'h001FFF
`define RTG_WD_1HZ_M1       21'h007FFF
`define RTG_WD_QHZ_M1       21'h01FFFF
`define RTG_WD_MIN_M1       21'h1DFFFF
`define RTG_WD_SEL_LAST     3'h4

`endif

// ---- logic/rtg_pkg.sv ----
/*
 * Types shared by the trim, guard and alert logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package rtg_pkg;
	// States of the interface guard countdown.
	typedef enum logic [1:0] {
		RTG_WD_IDLE = 2'b00,
		RTG_WD_RUN  = 2'b01,
		RTG_WD_DONE = 2'b10
	} rtg_guard_state_e;
endpackage : rtg_pkg

`default_nettype wire

// ---- logic/rtg_trim.sv ----
/*
 * Trimmed one-second time base with a 64 minute correction cycle.
 * Assumes osc_tick_in is a one-cycle pulse per oscillator period, already
 * synchronised to clk_in.
 */
`default_nettype none
`include "rtg_defines.svh"

module rtg_trim (
	input  wire logic       clk_in,       // Core clock.
	input  wire logic       srst_in,      // Synchronous reset, active high.
	input  wire logic       ce_in,        // Clock enable.
	input  wire logic       osc_tick_in,  // One pulse per oscillator cycle.
	input  wire logic       trim_sign_in, // One speeds up, zero slows down.
	input  wire logic [4:0] trim_mag_in,  // Trim magnitude field.
	output logic            sec_tick_out  // Trimmed second pulse.
);
	logic [15:0] osc_cnt_q; // Oscillator cycles in this second.
	logic [5:0]  sec_q;     // Second within the minute.
	logic [5:0]  min_q;     // Minute within the cycle; wraps at 64.

	// Number of event pairs for this setting.
	wire [5:0] pairs = trim_sign_in ?
		((trim_mag_in == 5'h00) ? 6'h1F : 6'h20 - {1'b0, trim_mag_in}) :
		{1'b0, trim_mag_in};
	// Two events per pair, one in the first second of each minute.
	wire [6:0] events = {pairs, 1'b0};
	wire       evt    = (sec_q == 6'h00) && ({1'b0, min_q} < events);
	// Length of this second; a corrected second is shorter or longer.
	wire [15:0] sec_len = !evt ? `RTG_SEC_OSC :
		(trim_sign_in ? `RTG_SEC_OSC - `RTG_TRIM_CUT :
		 `RTG_SEC_OSC + `RTG_TRIM_ADD);
	wire [15:0] sec_len_m1 = sec_len - 16'h0001;
	wire        sec_last   = osc_tick_in && (osc_cnt_q == sec_len_m1);

	// Counts oscillator cycles, seconds and minutes of the cycle.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			osc_cnt_q <= 16'h0000;
			sec_q     <= 6'h00;
			min_q     <= 6'h00;
		end else if (ce_in && osc_tick_in) begin
			osc_cnt_q <= sec_last ? 16'h0000 : osc_cnt_q + 16'h0001;
			if (sec_last) begin
				sec_q <= (sec_q == `RTG_SEC_PER_MIN_M1) ? 6'h00 : sec_q + 6'h01;
				if (sec_q == `RTG_SEC_PER_MIN_M1) begin
					min_q <= min_q + 6'h01;
				end
			end
		end
	end

	// The pulse is registered so the time counters see a clean strobe.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sec_tick_out <= 1'b0;
		end else if (ce_in) begin
			sec_tick_out <= sec_last;
		end
	end

	a_trim_idle: assert property (@(posedge clk_in) disable iff (srst_in)
		(!trim_sign_in && trim_mag_in == 5'h00) |-> !evt)
		else $error("Trim event with a zero setting.");
endmodule // rtg_trim

`default_nettype wire

// ---- logic/rtg_guard.sv ----
/*
 * Interface guard countdown with selectable tick source and multiplier.
 * Assumes ctrl_in already holds the new value in the cycle restart_in
 * is high, and that all inputs come from the clk_in domain.
 */
`default_nettype none
`include "rtg_defines.svh"

module rtg_guard (
	input  wire logic       clk_in,      // Core clock.
	input  wire logic       srst_in,     // Synchronous reset, active high.
	input  wire logic       ce_in,       // Clock enable.
	input  wire logic       osc_tick_in, // One pulse per oscillator cycle.
	input  wire logic [7:0] ctrl_in,     // Guard control register.
	input  wire logic       restart_in,  // Reload pulse after a write.
	input  wire logic       start_in,    // Serial transfer has begun.
	output logic            enabled_out, // Guard is set to interrupt.
	output logic            expire_out   // One-cycle expiry pulse.
);
	rtg_pkg::rtg_guard_state_e state_q; // Countdown state.
	rtg_pkg::rtg_guard_state_e state_d;
	logic [20:0] tick_q;                // Oscillator cycles in a tick.
	logic [4:0]  cnt_q;                 // Ticks still to go.
	logic [4:0]  cnt_d;

	wire [2:0] guard_tick_select = {ctrl_in[7], ctrl_in[1:0]};
	wire [4:0] guard_multiplier  = ctrl_in[6:2];
	wire       sel_ok = guard_tick_select <= `RTG_WD_SEL_LAST;
	assign enabled_out = (ctrl_in != 8'h00) && sel_ok;
	// Tick period chosen from the uncorrected divider chain.
	wire [20:0] div_m1 =
		(guard_tick_select == 3'h0) ? `RTG_WD_16HZ_M1 :
		(guard_tick_select == 3'h1) ? `RTG_WD_4HZ_M1 :
		(guard_tick_select == 3'h2) ? `RTG_WD_1HZ_M1 :
		(guard_tick_select == 3'h3) ? `RTG_WD_QHZ_M1 : `RTG_WD_MIN_M1;
	wire running  = state_q == rtg_pkg::RTG_WD_RUN;
	wire tick     = osc_tick_in && (tick_q == div_m1);
	wire reload   = restart_in || (state_q == rtg_pkg::RTG_WD_IDLE && start_in);
	// A zero multiplier expires one cycle after the load.
	assign expire_out = ce_in && enabled_out && running && !restart_in &&
		(cnt_q == 5'h00);

	// Next state; a disabled guard always falls back to idle.
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (!enabled_out) begin
			state_d = rtg_pkg::RTG_WD_IDLE;
		end else if (reload) begin
			state_d = rtg_pkg::RTG_WD_RUN;
			cnt_d   = guard_multiplier;
		end else begin
			case (state_q)
				rtg_pkg::RTG_WD_RUN: begin
					if (cnt_q == 5'h00) begin
						state_d = rtg_pkg::RTG_WD_DONE;
					end else if (tick) begin
						cnt_d = cnt_q - 5'h01;
					end
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	// The tick divider restarts with every reload so periods are whole.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= rtg_pkg::RTG_WD_IDLE;
			cnt_q   <= 5'h00;
			tick_q  <= 21'h000000;
		end else if (ce_in) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (reload || !running || tick) begin
				tick_q <= 21'h000000;
			end else if (osc_tick_in) begin
				tick_q <= tick_q + 21'h000001;
			end
		end
	end

	a_guard_bad_sel: assert property (@(posedge clk_in) disable iff (srst_in)
		(!sel_ok && ce_in) |=> (state_q == rtg_pkg::RTG_WD_IDLE))
		else $error("Guard runs with an invalid tick source.");
	a_guard_load: assert property (@(posedge clk_in) disable iff (srst_in)
		(restart_in && enabled_out && ce_in) |=>
		(running && cnt_q == $past(guard_multiplier)))
		else $error("Guard did not reload the multiplier.");
endmodule // rtg_guard

`default_nettype wire

// ---- logic/rtg_top.sv ----
/*
 * Trim, interface guard and repeatable alert logic of a calendar clock,
 * with the shared open-drain interrupt pin.
 * Assumes a serial slave engine in the clk_in domain that presents one
 * register access per strobe and the current address pointer, time
 * counters that feed back BCD time, and a free oscillator clock pin.
 */
`default_nettype none
`include "rtg_defines.svh"

// Functional notes
// - Trim cycle repeats every 64 minutes.
// - Slow-down: two events per magnitude unit, one per minute; speed-up uses 32 minus magnitude (31 at zero).
// - Speed-up cuts 256, slow-down adds 128 cycles.
// - Trim resets to no correction.
// - Square-wave divider never sees trim corrections.
// - Guard expiry sets flag bit 7, interrupt.
// - Guard register zero disables the guard.
// - Period is tick period times multiplier.
// - Tick select picks five source rates.
// - Select codes above four leave guard off.
// - Zero multiplier with nonzero select expires immediately.
// - Countdown starts when a serial transfer begins while the guard is idle.
// - Guard register write restarts the full period.
// - Guard register write releases guard interrupt.
// - Flag read clears guard expired flag.
// - Reset clears the guard register.
// - Clock register writes also restart guard.
// - Repeat bits choose the alert match scope.
// - Match sets alert flag, interrupt when enabled.
// - Pointer on flags suppresses alert flag, interrupt.
// - Flag read releases alert; next read shows zero.
// - Flags are read-only; WDF and AF are cleared by reading.
// - No source enabled: pin follows trim bit 7.
module rtg_top (
	input  wire logic       clk_in,           // Core clock, 125 MHz.
	input  wire logic       srst_in,          // Synchronous reset, high.
	input  wire logic       ce_in,            // Clock enable; low freezes.
	input  wire logic       osc_clk_in,       // Oscillator pin, async.
	input  wire logic       xfer_start_in,    // Serial transfer began.
	input  wire logic       reg_wr_in,        // Register write strobe.
	input  wire logic       reg_rd_in,        // Register read strobe.
	input  wire logic [3:0] reg_addr_in,      // Register offset.
	input  wire logic [7:0] reg_wdata_in,     // Write data.
	output logic      [7:0] reg_rdata_out,    // Read data, registered.
	input  wire logic [3:0] ptr_addr_in,      // Current address pointer.
	input  wire logic [7:0] time_sec_in,      // Current seconds, BCD.
	input  wire logic [7:0] time_min_in,      // Current minutes, BCD.
	input  wire logic [7:0] time_hour_in,     // Current hours, BCD.
	input  wire logic [7:0] time_date_in,     // Current date, BCD.
	input  wire logic [7:0] time_month_in,    // Current month, BCD.
	input  wire logic       osc_fail_flag_in, // Oscillator fail flag.
	input  wire logic       osc_fail_irq_enable_in, // Fail irq enable.
	output logic            sec_tick_out,     // Trimmed second pulse.
	output logic     [14:0] square_wave_div_out, // Uncorrected divider.
	input  wire logic       int_n_i_in,       // Interrupt pin level.
	output logic            int_n_o_out,      // Interrupt pin drive value.
	output logic            int_n_oe_out      // Interrupt pin pulls low.
);
	logic [2:0]  osc_sync_q; // Synchroniser pair and edge history.
	logic [7:0]  trim_q;     // Trim register.
	logic [7:0]  guard_q;    // Guard control register.
	logic [7:0]  month_q;    // Month alert register with enable bit.
	logic [7:0]  date_q;     // Date alert register.
	logic [7:0]  hour_q;     // Hour alert register.
	logic [7:0]  minute_q;   // Minute alert register.
	logic [7:0]  second_q;   // Second alert register.
	logic        wdf_q;      // Guard expired flag.
	logic        af_q;       // Alert match flag.
	logic        wd_irq_q;   // Guard interrupt request.
	logic        restart_q;  // Delayed restart so the guard sees new data.
	logic        sec_seen_q; // Second tick delayed for fresh time inputs.
	logic        int_oe_q;   // Registered pin pull-down.
	logic [14:0] sqw_q;      // Free-running oscillator divider.
	logic        guard_en;   // Guard set to interrupt.
	logic        guard_exp;  // Guard expiry pulse.

	// Oscillator edge after two synchroniser stages.
	wire osc_tick = osc_sync_q[1] && !osc_sync_q[2];

	// Access decode.
	wire wr_trim   = reg_wr_in && (reg_addr_in == `RTG_ADDR_TRIM);
	wire wr_guard  = reg_wr_in && (reg_addr_in == `RTG_ADDR_GUARD);
	wire wr_month  = reg_wr_in && (reg_addr_in == `RTG_ADDR_MONTH);
	wire wr_date   = reg_wr_in && (reg_addr_in == `RTG_ADDR_DATE);
	wire wr_hour   = reg_wr_in && (reg_addr_in == `RTG_ADDR_HOUR);
	wire wr_minute = reg_wr_in && (reg_addr_in == `RTG_ADDR_MINUTE);
	wire wr_second = reg_wr_in && (reg_addr_in == `RTG_ADDR_SECOND);
	wire wr_clock  = reg_wr_in && (reg_addr_in <= `RTG_ADDR_CLOCK_LAST);
	wire rd_flags  = reg_rd_in && (reg_addr_in == `RTG_ADDR_FLAGS);

	// Flag register image; unused bits read as zero.
	wire [7:0] flags_img = {wdf_q, af_q, 3'h0, osc_fail_flag_in, 2'h0};
	wire [7:0] rd_mux =
		(reg_addr_in == `RTG_ADDR_TRIM)   ? trim_q :
		(reg_addr_in == `RTG_ADDR_GUARD)  ? guard_q :
		(reg_addr_in == `RTG_ADDR_MONTH)  ? month_q :
		(reg_addr_in == `RTG_ADDR_DATE)   ? date_q :
		(reg_addr_in == `RTG_ADDR_HOUR)   ? hour_q :
		(reg_addr_in == `RTG_ADDR_MINUTE) ? minute_q :
		(reg_addr_in == `RTG_ADDR_SECOND) ? second_q :
		(reg_addr_in == `RTG_ADDR_FLAGS)  ? flags_img : 8'h00;

	// Alert scope from the five repeat bits, high to low.
	wire [4:0] alert_repeat_select =
		{date_q[6], date_q[7], hour_q[7], minute_q[7], second_q[7]};
	wire m_sec   = time_sec_in == {1'b0, second_q[6:0]};
	wire m_min   = time_min_in == {1'b0, minute_q[6:0]};
	wire m_hour  = time_hour_in[5:0] == hour_q[5:0];
	wire m_date  = time_date_in[5:0] == date_q[5:0];
	wire m_month = time_month_in[4:0] == month_q[4:0];
	// Unlisted codes fall back to every second to flag a bad setting.
	wire hit =
		(alert_repeat_select == 5'h1E) ? m_sec :
		(alert_repeat_select == 5'h1C) ? m_sec && m_min :
		(alert_repeat_select == 5'h18) ? m_sec && m_min && m_hour :
		(alert_repeat_select == 5'h10) ? m_sec && m_min && m_hour && m_date :
		(alert_repeat_select == 5'h00) ?
			m_sec && m_min && m_hour && m_date && m_month : 1'b1;
	// A pointer parked on the flags holds the alert off.
	wire alert_set = sec_seen_q && hit &&
		(ptr_addr_in != `RTG_ADDR_FLAGS);
	wire alert_flag_enable = month_q[`RTG_AFE_BIT];

	// Any source armed to interrupt takes the pin from the fallback level.
	wire src_en = osc_fail_irq_enable_in || alert_flag_enable || guard_en;
	wire irq_on = wd_irq_q || (af_q && alert_flag_enable) ||
		(osc_fail_flag_in && osc_fail_irq_enable_in);
	wire int_oe_d = src_en ? irq_on : !trim_q[`RTG_TRIM_OUT_BIT];

	// The pin only ever sinks; the pull-up gives the high level.
	assign int_n_o_out = 1'b0;
	assign square_wave_div_out = sqw_q;

	// Oscillator synchroniser; only stage one feeds stage two.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			osc_sync_q <= 3'h0;
		end else if (ce_in) begin
			osc_sync_q <= {osc_sync_q[1:0], osc_clk_in};
		end
	end

	// Square-wave divider runs off raw oscillator edges, untouched by trim.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sqw_q <= 15'h0000;
		end else if (ce_in && osc_tick) begin
			sqw_q <= sqw_q + 15'h0001;
		end
	end

	// Trim and guard control registers.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			trim_q  <= `RTG_TRIM_RST;
			guard_q <= `RTG_GUARD_RST;
		end else if (ce_in) begin
			if (wr_trim) begin
				trim_q <= reg_wdata_in;
			end
			if (wr_guard) begin
				guard_q <= reg_wdata_in;
			end
		end
	end

	// Alert match registers.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			month_q  <= `RTG_MONTH_RST;
			date_q   <= `RTG_ALERT_RST;
			hour_q   <= `RTG_ALERT_RST;
			minute_q <= `RTG_ALERT_RST;
			second_q <= `RTG_ALERT_RST;
		end else if (ce_in) begin
			if (wr_month) begin
				month_q <= reg_wdata_in;
			end
			if (wr_date) begin
				date_q <= reg_wdata_in;
			end
			if (wr_hour) begin
				hour_q <= reg_wdata_in;
			end
			if (wr_minute) begin
				minute_q <= reg_wdata_in;
			end
			if (wr_second) begin
				second_q <= reg_wdata_in;
			end
		end
	end

	// Restart waits one cycle so the guard reloads from the new value.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			restart_q  <= 1'b0;
			sec_seen_q <= 1'b0;
		end else if (ce_in) begin
			restart_q  <= wr_guard || wr_clock;
			sec_seen_q <= sec_tick_out;
		end
	end

	// Flags are only set by events and cleared by reads, the guard request by guard writes; set beats clear.
	// Writes to the flag offset are ignored.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wdf_q    <= 1'b0;
			af_q     <= 1'b0;
			wd_irq_q <= 1'b0;
		end else if (ce_in) begin
			wdf_q    <= guard_exp || (wdf_q && !rd_flags);
			af_q     <= alert_set || (af_q && !rd_flags);
			wd_irq_q <= guard_exp || (wd_irq_q && !wr_guard);
		end
	end

	// Read data is captured with the read, so a flag shows once as set.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= 8'h00;
			int_oe_q      <= 1'b0;
		end else if (ce_in) begin
			if (reg_rd_in) begin
				reg_rdata_out <= rd_mux;
			end
			int_oe_q <= int_oe_d;
		end
	end
	assign int_n_oe_out = int_oe_q;

	// Trimmed time base.
	rtg_trim u_trim (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.ce_in        (ce_in),
		.osc_tick_in  (osc_tick),
		.trim_sign_in (trim_q[`RTG_TRIM_SIGN_BIT]),
		.trim_mag_in  (trim_q[4:0]),
		.sec_tick_out (sec_tick_out)
	);

	// Interface guard countdown.
	rtg_guard u_guard (
		.clk_in      (clk_in),
		.srst_in     (srst_in),
		.ce_in       (ce_in),
		.osc_tick_in (osc_tick),
		.ctrl_in     (guard_q),
		.restart_in  (restart_q),
		.start_in    (xfer_start_in),
		.enabled_out (guard_en),
		.expire_out  (guard_exp)
	);

	a_wdf_set: assert property (@(posedge clk_in) disable iff (srst_in)
		guard_exp |=> wdf_q)
		else $error("Guard expiry did not set the flag.");
	a_wd_int_pin: assert property (@(posedge clk_in) disable iff (srst_in)
		(wd_irq_q && ce_in) |=> int_n_oe_out)
		else $error("Guard interrupt not on the pin.");
	a_wd_release: assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_guard && !guard_exp && ce_in) |=> !wd_irq_q)
		else $error("Guard write did not release the interrupt.");
	a_wdf_read_clr: assert property (@(posedge clk_in) disable iff (srst_in)
		(rd_flags && !guard_exp && ce_in) |=> !wdf_q)
		else $error("Flag read did not clear the guard flag.");
	a_ptr_suppress: assert property (@(posedge clk_in) disable iff (srst_in)
		(ptr_addr_in == `RTG_ADDR_FLAGS && !af_q) |=> !af_q)
		else $error("Alert flag set while pointer on flags.");
	a_af_read_once: assert property (@(posedge clk_in) disable iff (srst_in)
		(rd_flags && af_q && !alert_set && ce_in) |=>
		(reg_rdata_out[`RTG_AF_BIT] && !af_q))
		else $error("Alert flag read not shown once then cleared.");
	a_out_level: assert property (@(posedge clk_in) disable iff (srst_in)
		(!src_en && ce_in) |=>
		(int_n_oe_out == !$past(trim_q[`RTG_TRIM_OUT_BIT])))
		else $error("Pin does not follow the fallback level.");
	// Checks on alert, restart and divider paths; the bench never reaches the alert ones.
	// An alert match sets the flag on the following edge.
	a_af_set: assert property (@(posedge clk_in) disable iff (srst_in)
		(alert_set && ce_in) |=> af_q)
		else $error("Alert match did not set the flag.");
	// A clock register write must reach the guard as a restart.
	a_clk_restart: assert property (@(posedge clk_in) disable iff (srst_in)
		(wr_clock && ce_in) |=> restart_q)
		else $error("Clock write did not restart the guard.");
	// The divider steps on every oscillator edge, whatever the trim does.
	a_sqw_step: assert property (@(posedge clk_in) disable iff (srst_in)
		(osc_tick && ce_in) |=>
		(square_wave_div_out == $past(square_wave_div_out) + 15'h0001))
		else $error("Square-wave divider missed an oscillator edge.");
	// An enabled alert flag pulls the pin low one edge later.
	a_af_pin: assert property (@(posedge clk_in) disable iff (srst_in)
		(af_q && alert_flag_enable && ce_in) |=> int_n_oe_out)
		else $error("Alert interrupt not on the pin.");
endmodule // rtg_top

`default_nettype wire

// ---- dv/rtg_host.sv ----
/*
 * Host model that reaches the registers one byte per strobe.
 * Assumes the strobe is taken at the rising edge of clk_in.
 */
`default_nettype none

module rtg_host (
	input  wire logic       clk_in,    // Core clock.
	output logic            wr_out,    // Write strobe.
	output logic            rd_out,    // Read strobe.
	output logic      [3:0] addr_out,  // Register offset.
	output logic      [7:0] wdata_out, // Write data.
	output logic            start_out  // Serial transfer began.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Everything idles low until the first access.
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 4'h0;
		wdata_out = 8'h00;
		start_out = 1'b0;
	end

	// One access; released data shows its inverse so stale bytes never match.
	task automatic access(input logic wr, input logic [3:0] a,
			input logic [7:0] d);
		@(negedge clk_in);
		wr_out = wr;
		rd_out = !wr;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = ~d;
	endtask

	// The host restarts the guard by writing its register; a clock register write also restarts it.
	task automatic kick(input logic [7:0] d);
		access(1'b1, 4'h9, d);
	endtask

	// Turning the alert off zeroes the date field and all repeat bits.
	task automatic alert_off();
		access(1'b1, 4'hB, 8'h00);
		access(1'b1, 4'hC, 8'h00);
		access(1'b1, 4'hD, 8'h00);
		access(1'b1, 4'hE, 8'h00);
	endtask

	// Marks the opening of a serial transfer for one cycle.
	task automatic begin_xfer();
		@(negedge clk_in);
		start_out = 1'b1;
		@(negedge clk_in);
		start_out = 1'b0;
	endtask
endmodule // rtg_host

`default_nettype wire

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the trim, guard and alert logic.
 * Assumes the oscillator pin is free running and the pin has a pull-up.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_in = 1'b0;   // Core clock, 8 ns.
	logic        osc = 1'b0;      // Oscillator pin, 160 ns.
	logic        srst_in = 1'b1;  // Reset, held at start.
	logic        of_flag = 1'b0;  // Oscillator fail level.
	logic        of_ie = 1'b0;    // Oscillator fail enable.
	logic  [3:0] ptr;             // Address pointer.
	logic  [7:0] tm [5];          // Current time bytes.
	logic        wr, rd, xs;      // Host strobes.
	logic  [3:0] addr;            // Host offset.
	logic  [7:0] wdata, rdata;    // Data both ways.
	logic        oe;              // Pin pulled low.
	logic        pin_o;           // Pin drive value.
	logic        ce = 1'b1;       // Clock enable.
	logic [14:0] sqw, sqw0;       // Divider now and at a start mark.
	logic  [7:0] exp_q [$];       // Expected read bytes.
	logic  [7:0] v;               // Scratch value.
	int          num_errors = 0;  // Mismatches.
	int          checked = 0;     // Comparisons.
	int          cycles = 0;      // Timeout count.

	always #4 clk_in = ~clk_in;
	always #80 osc = ~osc;

	rtg_host host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
		.addr_out(addr), .wdata_out(wdata), .start_out(xs));

	rtg_top DUT (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
		.osc_clk_in(osc), .xfer_start_in(xs), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .ptr_addr_in(ptr), .time_sec_in(tm[0]),
		.time_min_in(tm[1]), .time_hour_in(tm[2]), .time_date_in(tm[3]),
		.time_month_in(tm[4]), .osc_fail_flag_in(of_flag),
		.osc_fail_irq_enable_in(of_ie), .sec_tick_out(),
		.square_wave_div_out(sqw), .int_n_i_in(~oe), .int_n_o_out(pin_o),
		.int_n_oe_out(oe));

	// Compares one value and counts it.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Reads a register after noting what it should return.
	task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Each taken read yields its byte at that rising edge; it is checked half a clock later.
	always @(posedge clk_in) begin
		if (rd === 1'b1) begin
			@(negedge clk_in);
			check(rdata, exp_q.pop_front());
		end
	end

	// A hang is cut short well after the one 16 Hz guard period the bench waits for.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 90000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		void'($urandom(15369));
		ptr = 4'($urandom_range(14, 0));
		foreach (tm[i])
			tm[i] = 8'($urandom_range(8'h28, 1));
		repeat (2) @(negedge clk_in);
		srst_in = 1'b0;
		rd_exp(4'h8, 8'h80);
		rd_exp(4'h9, 8'h00);
		rd_exp(4'hF, 8'h00);
		check({7'h00, oe}, 8'h00);
		check({7'h00, pin_o}, 8'h00);
		// Alert bytes hold what was written, then the host turns them off.
		for (int a = 11; a <= 14; a++) begin
			v = 8'($urandom);
			host.access(1'b1, 4'(a), v);
			rd_exp(4'(a), v);
		end
		host.alert_off();
		// Fallback level follows the trim top bit while nothing interrupts.
		host.access(1'b1, 4'h8, 8'h00);
		repeat (3) @(negedge clk_in);
		check({7'h00, oe}, 8'h01);
		// A low clock enable freezes all state, so this write is lost.
		ce = 1'b0;
		host.access(1'b1, 4'h8, 8'h80);
		check({7'h00, oe}, 8'h01);
		ce = 1'b1;
		rd_exp(4'h8, 8'h00);
		v = {2'b10, 6'($urandom)};
		host.access(1'b1, 4'h8, v);
		rd_exp(4'h8, v);
		check({7'h00, oe}, 8'h00);
		// Invalid tick codes keep the guard off despite a multiplier.
		for (int s = 5; s <= 7; s++) begin
			v = {s[2], 5'd5, s[1:0]};
			host.kick(v);
			repeat (20) @(negedge clk_in);
			check({7'h00, oe}, 8'h00);
			rd_exp(4'h9, v);
		end
		// A zero multiplier on every valid nonzero code expires at once.
		for (int s = 1; s <= 4; s++) begin
			host.kick({s[2], 5'd0, s[1:0]});
			repeat (6) @(negedge clk_in);
			check({7'h00, oe}, 8'h01);
			rd_exp(4'hF, 8'h80);
			rd_exp(4'hF, 8'h00);
			check({7'h00, oe}, 8'h01);
			host.kick(8'h00);
			repeat (4) @(negedge clk_in);
			check({7'h00, oe}, 8'h00);
		end
		// Oscillator fail with its enable pulls the pin low.
		of_flag = 1'b1;
		of_ie = 1'b1;
		repeat (3) @(negedge clk_in);
		check({7'h00, oe}, 8'h01);
		rd_exp(4'hF, 8'h04);
		of_flag = 1'b0;
		of_ie = 1'b0;
		// The divider counts every oscillator edge: ten in 1600 ns.
		sqw0 = sqw;
		repeat (200) @(negedge clk_in);
		check(8'(sqw - sqw0), 8'h0A);
		// One 16 Hz tick: a clock write midway restarts the full period.
		host.begin_xfer();
		host.kick(8'h04);
		repeat (20000) @(negedge clk_in);
		host.access(1'b1, 4'h0, 8'h00);
		repeat (40900) @(negedge clk_in);
		check({7'h00, oe}, 8'h00);
		for (int i = 0; i < 200 && oe !== 1'b1; i++)
			@(negedge clk_in);
		check({7'h00, oe}, 8'h01);
		rd_exp(4'hF, 8'h80);
		repeat (2) @(negedge clk_in);
		final_report();
	end
endmodule // testbench

`default_nettype wire
